/* File: design/apms_edge.sv */
// apms_edge: rise and fall pulses of the active-low sample trigger
// assumes the trigger is already synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module apms_edge (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // trigger
  input  wire logic trig_n,
  output logic      rise,
  output logic      fall
);
  apms_pkg::apms_edge_s st_q;
  apms_pkg::apms_edge_s st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.prev = trig_n;
    st_d.rise = trig_n & ~st_q.prev;
    st_d.fall = ~trig_n & st_q.prev;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_q <= '{prev: apms_pkg::TRIG_IDLE, rise: 1'b0, fall: 1'b0};
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  assign rise = st_q.rise;
  assign fall = st_q.fall;

  chk_edge_rise_fall: assert property (@(posedge core_clk) disable iff (sys_rst) !(rise && fall))
    else $error("trigger rise and fall together");
endmodule
`default_nettype wire

/* File: design/apms_pkg.sv */
// apms_pkg: constants and types of the adc power-mode sequencer
// assumes a 250 MHz core clock; all time figures are converted here
package apms_pkg;

  // ****************************************
  // clock and time figures
  // ****************************************
  localparam int unsigned CLK_MHZ    = 250;
  localparam int unsigned TIMEOUT_MS = 32;
  localparam int unsigned CAL_MS     = 32;
  localparam int unsigned WAKE_NS    = 5000;
  localparam int unsigned CONV_NS    = 4600;
  localparam int unsigned RATE_KSPS  = 100;

  // least times round up to whole cycles
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int unsigned CAL_CYC     = CAL_MS * CLK_MHZ * 1000;
  localparam int unsigned WAKE_CYC    = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC    = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RATE_CYC    = (CLK_MHZ * 1000 + RATE_KSPS - 1) / RATE_KSPS;

  localparam int unsigned TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
  localparam logic [TMR_W-1:0] TMR_ONE  = 24'h000001;

  // ****************************************
  // power-mode field
  // ****************************************
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_PD_AFTER = 2'h1;
  localparam logic [1:0] MODE_PD_NOW   = 2'h2;
  localparam logic [1:0] MODE_PART     = 2'h3;
  localparam logic [1:0] MODE_RESET    = MODE_NORMAL;

  localparam logic TRIG_IDLE = 1'b1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_PU_IDLE = 3'h0,
    ST_PU_TOUT = 3'h1,
    ST_PU_WAIT = 3'h3,
    ST_PU_CAL  = 3'h2,
    ST_IDLE    = 3'h6,
    ST_CONV    = 3'h7,
    ST_PWRDN   = 3'h5,
    ST_WAKE    = 3'h4
  } apms_state_e;

  typedef struct packed {
    apms_state_e state;
    logic [1:0]  mode;
    logic        skip_cal;
    logic        busy;
    logic        core_on;
    logic        ref_on;
    logic        cal_run;
    logic        conv_pulse;
  } apms_seq_s;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } apms_tmr_s;

  typedef struct packed {
    logic prev;
    logic rise;
    logic fall;
  } apms_edge_s;

endpackage

/* File: design/apms_sequencer.sv */
// apms_sequencer: power-mode and power-up sequencing of a sampling converter
// assumes host inputs are synchronous to core_clk; ctrl_wr is a one-cycle
// strobe carrying the new power-mode bits
`timescale 1ns/10ps
`default_nettype none

module apms_sequencer #(
  parameter int unsigned TIMEOUT_CYC = apms_pkg::TIMEOUT_CYC,
  parameter int unsigned CAL_CYC     = apms_pkg::CAL_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // host side
  input  wire logic sample_trigger_n,
  input  wire logic ctrl_wr,
  input  wire logic power_mode_bit_hi,
  input  wire logic power_mode_bit_lo,
  // status and power controls
  output logic      busy,
  output logic      core_pwr_on,
  output logic      ref_pwr_on,
  output logic      cal_active,
  output logic      conv_start
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic pd_after(input logic [1:0] m);
    pd_after = (m == apms_pkg::MODE_PD_AFTER) || (m == apms_pkg::MODE_PART);
  endfunction

  function automatic logic ref_kept(input logic [1:0] m);
    ref_kept = (m == apms_pkg::MODE_PART);
  endfunction

  localparam logic [apms_pkg::TMR_W-1:0] LD_TOUT = apms_pkg::TMR_W'(TIMEOUT_CYC);
  localparam logic [apms_pkg::TMR_W-1:0] LD_CAL  = apms_pkg::TMR_W'(CAL_CYC);
  localparam logic [apms_pkg::TMR_W-1:0] LD_WAKE = apms_pkg::TMR_W'(apms_pkg::WAKE_CYC);
  localparam logic [apms_pkg::TMR_W-1:0] LD_CONV = apms_pkg::TMR_W'(apms_pkg::CONV_CYC);
  localparam logic [apms_pkg::TMR_W-1:0] LD_RATE = apms_pkg::TMR_W'(apms_pkg::RATE_CYC);

  apms_pkg::apms_seq_s st_q;
  apms_pkg::apms_seq_s st_d;
  logic [1:0]          wr_mode;
  logic                rise;
  logic                fall;

  apms_tmr_if tm ();
  apms_tmr_if tr ();

  assign wr_mode = {power_mode_bit_hi, power_mode_bit_lo};

  // ****************************************
  // submodules
  // ****************************************
  apms_edge u_edge (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .trig_n   (sample_trigger_n),
    .rise     (rise),
    .fall     (fall)
  );

  apms_timer u_tmain (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .tif      (tm.tmr)
  );

  // rate timer spaces conversion starts while powering down between them
  apms_timer u_trate (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .tif      (tr.tmr)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    st_d            = st_q;
    st_d.conv_pulse = 1'b0;
    tm.load         = 1'b0;
    tm.count        = LD_CONV;
    tr.load         = 1'b0;
    tr.count        = LD_RATE;
    if (ctrl_wr)
    begin
      st_d.mode = wr_mode;
    end
    case (st_q.state)
      apms_pkg::ST_PU_IDLE:
      begin
        if (ctrl_wr)
        begin
          st_d.state = apms_pkg::ST_IDLE;
        end
        else if (rise)
        begin
          st_d.state = apms_pkg::ST_PU_TOUT;
          st_d.busy  = 1'b1;
          tm.load    = 1'b1;
          tm.count   = LD_TOUT;
        end
      end
      apms_pkg::ST_PU_TOUT:
      begin
        if (ctrl_wr)
        begin
          st_d.skip_cal = 1'b1;
        end
        if (tm.done)
        begin
          st_d.busy  = 1'b0;
          st_d.state = (st_q.skip_cal || ctrl_wr) ? apms_pkg::ST_IDLE : apms_pkg::ST_PU_WAIT;
        end
      end
      apms_pkg::ST_PU_WAIT:
      begin
        if (ctrl_wr)
        begin
          st_d.state = apms_pkg::ST_IDLE;
        end
        else if (rise)
        begin
          st_d.state   = apms_pkg::ST_PU_CAL;
          st_d.busy    = 1'b1;
          st_d.cal_run = 1'b1;
          tm.load      = 1'b1;
          tm.count     = LD_CAL;
        end
      end
      apms_pkg::ST_PU_CAL:
      begin
        // writes only change the mode here, never the calibration
        if (tm.done)
        begin
          st_d.state   = apms_pkg::ST_IDLE;
          st_d.busy    = 1'b0;
          st_d.cal_run = 1'b0;
        end
      end
      apms_pkg::ST_IDLE:
      begin
        if (st_q.mode == apms_pkg::MODE_PD_NOW)
        begin
          st_d.state   = apms_pkg::ST_PWRDN;
          st_d.core_on = 1'b0;
          st_d.ref_on  = 1'b0;
        end
        else if (rise && !st_q.busy)
        begin
          st_d.state      = apms_pkg::ST_CONV;
          st_d.busy       = 1'b1;
          st_d.conv_pulse = 1'b1;
          tm.load         = 1'b1;
          tm.count        = LD_CONV;
          tr.load         = pd_after(st_q.mode);
        end
      end
      apms_pkg::ST_CONV:
      begin
        if (st_q.mode == apms_pkg::MODE_PD_NOW)
        begin
          st_d.state   = apms_pkg::ST_PWRDN;
          st_d.busy    = 1'b0;
          st_d.core_on = 1'b0;
          st_d.ref_on  = 1'b0;
        end
        else if (tm.done)
        begin
          st_d.busy = 1'b0;
          if (pd_after(st_q.mode))
          begin
            st_d.state   = apms_pkg::ST_PWRDN;
            st_d.core_on = 1'b0;
            st_d.ref_on  = ref_kept(st_q.mode);
          end
          else
          begin
            st_d.state = apms_pkg::ST_IDLE;
          end
        end
      end
      apms_pkg::ST_PWRDN:
      begin
        if ((ctrl_wr && wr_mode != apms_pkg::MODE_PD_NOW) ||
            (!ctrl_wr && st_q.mode != apms_pkg::MODE_PD_NOW && fall && tr.done))
        begin
          st_d.state   = apms_pkg::ST_WAKE;
          st_d.core_on = 1'b1;
          st_d.ref_on  = 1'b1;
          tm.load      = 1'b1;
          tm.count     = LD_WAKE;
        end
        else if (ctrl_wr)
        begin
          // an immediate full power-down also drops a kept reference
          st_d.ref_on = 1'b0;
        end
      end
      apms_pkg::ST_WAKE:
      begin
        // a rise before readiness is dropped: the host must hold the pin low
        if (tm.done)
        begin
          st_d.state = apms_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d.state = apms_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_q <= '{state: apms_pkg::ST_PU_IDLE, mode: apms_pkg::MODE_RESET,
                skip_cal: 1'b0, busy: 1'b0, core_on: 1'b1, ref_on: 1'b1,
                cal_run: 1'b0, conv_pulse: 1'b0};
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  assign busy        = st_q.busy;
  assign core_pwr_on = st_q.core_on;
  assign ref_pwr_on  = st_q.ref_on;
  assign cal_active  = st_q.cal_run;
  assign conv_start  = st_q.conv_pulse;

  // ****************************************
  // checks
  // ****************************************
  logic [11:0] conv_cnt_q;
  logic [11:0] wake_cnt_q;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || st_q.state != apms_pkg::ST_CONV)
    begin
      conv_cnt_q <= 12'h000;
    end
    else if (clk_en)
    begin
      conv_cnt_q <= conv_cnt_q + 12'h001;
    end
    // wake span is too long for a delay range, so it is counted here
    if (sys_rst || st_q.state != apms_pkg::ST_WAKE)
    begin
      wake_cnt_q <= 12'h000;
    end
    else if (clk_en)
    begin
      wake_cnt_q <= wake_cnt_q + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  chk_mode_now_pd: assert property (st_q.state == apms_pkg::ST_IDLE && st_q.mode == apms_pkg::MODE_PD_NOW
    |=> st_q.state == apms_pkg::ST_PWRDN && !core_pwr_on) else $error("pd-now not taken");
  chk_pd_power_off: assert property (st_q.state == apms_pkg::ST_PWRDN
    |-> !core_pwr_on && (ref_pwr_on == ref_kept(st_q.mode) || st_q.mode != apms_pkg::MODE_PD_NOW))
    else $error("power rails wrong in pd");
  chk_first_timeout: assert property (st_q.state == apms_pkg::ST_PU_IDLE && rise && !ctrl_wr
    |=> st_q.state == apms_pkg::ST_PU_TOUT && busy) else $error("first trigger missed");
  chk_early_write: assert property (st_q.state == apms_pkg::ST_PU_IDLE && ctrl_wr
    |=> st_q.state == apms_pkg::ST_IDLE && !busy) else $error("early write not honoured");
  chk_wake_time: assert property ($fell(st_q.state == apms_pkg::ST_WAKE)
    |-> $past(wake_cnt_q) == 12'(apms_pkg::WAKE_CYC)) else $error("wake time wrong");
  chk_pd_after_conv: assert property (st_q.state == apms_pkg::ST_CONV && tm.done && pd_after(st_q.mode)
    |=> st_q.state == apms_pkg::ST_PWRDN && $fell(busy)) else $error("no pd after conversion");
  chk_fall_wakes: assert property (st_q.state == apms_pkg::ST_PWRDN && fall && tr.done && !ctrl_wr
    && st_q.mode != apms_pkg::MODE_PD_NOW |=> st_q.state == apms_pkg::ST_WAKE && core_pwr_on)
    else $error("fall did not wake");
  chk_rise_converts: assert property (st_q.state == apms_pkg::ST_IDLE && rise
    && st_q.mode != apms_pkg::MODE_PD_NOW |=> conv_start && busy) else $error("rise did not convert");
  chk_conv_length: assert property ($fell(st_q.state == apms_pkg::ST_CONV) && $past(tm.done)
    |-> $past(conv_cnt_q) == 12'(apms_pkg::CONV_CYC)) else $error("conversion length wrong");
  chk_rate_limit: assert property (st_q.state == apms_pkg::ST_PWRDN && !tr.done && !ctrl_wr
    |=> st_q.state == apms_pkg::ST_PWRDN) else $error("wake inside rate window");
  chk_busy_gate: assert property (busy && rise && !tm.done && st_q.mode != apms_pkg::MODE_PD_NOW
    |=> $stable(st_q.state) && !conv_start) else $error("trigger taken while busy");
  chk_write_timeout: assert property (st_q.state == apms_pkg::ST_PU_TOUT && ctrl_wr && !tm.done
    |=> busy && st_q.skip_cal) else $error("timeout write mishandled");
  chk_cal_kept: assert property (st_q.state == apms_pkg::ST_PU_CAL && !tm.done
    |=> st_q.state == apms_pkg::ST_PU_CAL && busy) else $error("calibration aborted");

  cov_full_cal: cover property ($fell(cal_active));
  cov_pd_cycle: cover property (st_q.state == apms_pkg::ST_PWRDN ##1 st_q.state == apms_pkg::ST_WAKE);
  cov_partial_pd: cover property (st_q.state == apms_pkg::ST_PWRDN && ref_pwr_on);
  cov_skip_cal: cover property (st_q.state == apms_pkg::ST_PU_TOUT && ctrl_wr);

endmodule
`default_nettype wire

/* File: design/apms_timer.sv */
// apms_timer: down-counter, done after exactly count enabled cycles
// assumes load is a single-cycle request from the sequencer
`timescale 1ns/10ps
`default_nettype none
module apms_timer (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // control
  apms_tmr_if.tmr   tif
);
  apms_pkg::apms_tmr_s st_q;
  apms_pkg::apms_tmr_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (tif.load)
    begin
      st_d.cnt = tif.count;
    end
    else if (st_q.cnt != apms_pkg::TMR_ZERO)
    begin
      st_d.cnt = st_q.cnt - apms_pkg::TMR_ONE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_q <= '{cnt: apms_pkg::TMR_ZERO};
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  // idle timer reads as done so a fresh rate window starts open
  assign tif.done = (st_q.cnt == apms_pkg::TMR_ZERO);

  chk_timer_load_busy: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    tif.load && tif.count > apms_pkg::TMR_ONE |=> !tif.done)
    else $error("timer done right after a load");
endmodule
`default_nettype wire

/* File: design/apms_tmr_if.sv */
// apms_tmr_if: load/count/done link between sequencer and a down-timer
// assumes both ends share core_clk
`timescale 1ns/10ps
`default_nettype none
interface apms_tmr_if;
  logic                     load;
  logic [apms_pkg::TMR_W-1:0] count;
  logic                     done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

/* File: sim/apms_host.sv */
// apms_host: host model driving the sample trigger and control writes
// assumes the bench calls its tasks; drives 1 ns after core_clk rises
`timescale 1ns/10ps
`default_nettype none
module apms_host (
  // clock
  input  wire logic core_clk,
  // host outputs
  output var logic  sample_trigger_n,
  output var logic  ctrl_wr,
  output var logic  power_mode_bit_hi,
  output var logic  power_mode_bit_lo
);
  // ****************************************
  // drivers
  // ****************************************
  initial
  begin
    sample_trigger_n  = 1'b1;
    ctrl_wr           = 1'b0;
    power_mode_bit_hi = 1'b0;
    power_mode_bit_lo = 1'b0;
  end

  // one-cycle write; bits inverted after, as they carry nothing then
  task automatic write(input logic [1:0] m);
    @(posedge core_clk);
    #1;
    ctrl_wr = 1'b1;
    {power_mode_bit_hi, power_mode_bit_lo} = m;
    @(posedge core_clk);
    #1;
    ctrl_wr = 1'b0;
    {power_mode_bit_hi, power_mode_bit_lo} = ~m;
  endtask

  task automatic level(input logic v);
    @(posedge core_clk);
    #1;
    sample_trigger_n = v;
  endtask

  // converting after a wake from power-down needs low_cyc above the wake span
  task automatic pulse(input int low_cyc);
    level(1'b0);
    repeat (low_cyc) @(posedge core_clk);
    level(1'b1);
  endtask
endmodule
`default_nettype wire

/* File: sim/apms_sequencer_tb.sv */
// apms_sequencer_tb: self-checking bench of the power-mode sequencer
// assumes apms_host as the host; short power-up counts keep the run brief
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end
module apms_sequencer_tb;
  // ****************************************
  // signals
  // ****************************************
  localparam int unsigned TOUT = 200;
  localparam int unsigned CAL  = 300;
  localparam int unsigned CONV = apms_pkg::CONV_CYC;
  localparam int unsigned WAKE = apms_pkg::WAKE_CYC;
  logic      core_clk;
  logic      sys_rst;
  logic      clk_en;
  logic      busy;
  logic      core_pwr_on;
  logic      ref_pwr_on;
  logic      cal_active;
  logic      conv_start;
  wire logic trig_n;
  wire logic wr;
  wire logic bhi;
  wire logic blo;
  int        fail_count;
  int        compares;
  int        n;
  int        cs;
  int        ca;

  apms_host u_host (
    .core_clk          (core_clk),
    .sample_trigger_n  (trig_n),
    .ctrl_wr           (wr),
    .power_mode_bit_hi (bhi),
    .power_mode_bit_lo (blo)
  );

  apms_sequencer #(.TIMEOUT_CYC(TOUT), .CAL_CYC(CAL)) u_dut (
    .core_clk          (core_clk),
    .sys_rst           (sys_rst),
    .clk_en            (clk_en),
    .sample_trigger_n  (trig_n),
    .ctrl_wr           (wr),
    .power_mode_bit_hi (bhi),
    .power_mode_bit_lo (blo),
    .busy              (busy),
    .core_pwr_on       (core_pwr_on),
    .ref_pwr_on        (ref_pwr_on),
    .cal_active        (cal_active),
    .conv_start        (conv_start)
  );

  always #2 core_clk = ~core_clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic tick;
    @(posedge core_clk);
    #2;
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    #1;
    sys_rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
  endtask

  // busy span, conv_start pulses and calibration cycles of one operation
  task automatic run(input int lim, output int nb, output int nc, output int na);
    int w;
    w = 0;
    nb = 0;
    nc = 0;
    na = 0;
    while (busy !== 1'b1 && w < lim)
    begin
      if (conv_start === 1'b1) nc++;
      tick;
      w++;
    end
    while (busy === 1'b1 && nb < 20000)
    begin
      if (conv_start === 1'b1) nc++;
      if (cal_active === 1'b1) na++;
      tick;
      nb++;
    end
  endtask

  task automatic conv(output int nb, output int nc, output int na);
    fork
      u_host.pulse(4);
      run(50, nb, nc, na);
    join
  endtask

  function automatic logic near(input int v, input int e);
    return (v >= e - 2 && v <= e + 2);
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    do_reset;
    tick;
    `CHK("busy", 1'b0, busy)
    `CHK("core", 1'b1, core_pwr_on)
    `CHK("ref", 1'b1, ref_pwr_on)
    `CHK("cal", 1'b0, cal_active)
    $display("test reset done");
  endtask

  // extra trigger in timeout ignored; write in calibration keeps it going
  task automatic t_powerup;
    do_reset;
    fork
      u_host.pulse(4);
      begin repeat (60) tick; u_host.pulse(4); end
      run(50, n, cs, ca);
    join
    `CHK("tout len", 1'b1, near(n, TOUT))
    `CHK("tout conv", 0, cs)
    fork
      u_host.pulse(4);
      begin repeat (100) tick; u_host.write(apms_pkg::MODE_NORMAL); end
      run(50, n, cs, ca);
    join
    `CHK("cal len", 1'b1, near(ca, CAL))
    `CHK("cal busy", 1'b1, near(n, CAL))
    conv(n, cs, ca);
    `CHK("conv pulses", 1, cs)
    `CHK("conv len", 1'b1, near(n, CONV))
    $display("test powerup done");
  endtask

  task automatic t_skip;
    do_reset;
    u_host.write(apms_pkg::MODE_NORMAL);
    conv(n, cs, ca);
    `CHK("skip conv", 1, cs)
    `CHK("skip cal", 0, ca)
    do_reset;
    fork
      u_host.pulse(4);
      begin repeat (50) tick; u_host.write(apms_pkg::MODE_NORMAL); end
      run(50, n, cs, ca);
    join
    `CHK("tout kept", 1'b1, near(n, TOUT))
    conv(n, cs, ca);
    `CHK("then conv", 1, cs)
    `CHK("then no cal", 0, ca)
    $display("test skip done");
  endtask

  task automatic t_pd_after;
    do_reset;
    u_host.write(apms_pkg::MODE_PD_AFTER);
    conv(n, cs, ca);
    `CHK("conv", 1, cs)
    `CHK("core off", 1'b0, core_pwr_on)
    `CHK("ref off", 1'b0, ref_pwr_on)
    u_host.level(1'b0);
    repeat (10) tick;
    `CHK("rate gate", 1'b0, core_pwr_on)
    u_host.level(1'b1);
    repeat (2600) tick;
    u_host.level(1'b0);
    repeat (4) tick;
    `CHK("wake", 1'b1, core_pwr_on)
    repeat (WAKE / 2) tick;
    u_host.level(1'b1);
    repeat (50) tick;
    `CHK("early rise", 1'b0, busy)
    repeat (WAKE) tick;
    conv(n, cs, ca);
    `CHK("idle conv", 1, cs)
    `CHK("re-pd core", 1'b0, core_pwr_on)
    repeat (2600) tick;
    fork
      u_host.pulse(WAKE + 4);
      run(WAKE + 60, n, cs, ca);
    join
    `CHK("woken conv", 1, cs)
    $display("test pd_after done");
  endtask

  task automatic t_modes;
    do_reset;
    u_host.write(apms_pkg::MODE_PART);
    conv(n, cs, ca);
    `CHK("part core", 1'b0, core_pwr_on)
    `CHK("part ref", 1'b1, ref_pwr_on)
    do_reset;
    u_host.write(apms_pkg::MODE_NORMAL);
    fork
      u_host.pulse(4);
      begin repeat (100) tick; u_host.write(apms_pkg::MODE_PD_NOW); end
      run(50, n, cs, ca);
    join
    tick;
    `CHK("abort", 1'b1, n < CONV)
    `CHK("now core", 1'b0, core_pwr_on)
    `CHK("now ref", 1'b0, ref_pwr_on)
    u_host.pulse(4);
    repeat (50) tick;
    `CHK("pd trig", 1'b0, busy)
    u_host.write(apms_pkg::MODE_NORMAL);
    repeat (3) tick;
    `CHK("sw wake", 1'b1, core_pwr_on)
    repeat (WAKE + 4) tick;
    conv(n, cs, ca);
    `CHK("after wake", 1, cs)
    `CHK("normal core", 1'b1, core_pwr_on)
    $display("test modes done");
  endtask

  // a frozen enable stretches a conversion by the frozen cycles
  task automatic t_freeze;
    do_reset;
    u_host.write(apms_pkg::MODE_NORMAL);
    fork
      u_host.pulse(4);
      begin
        repeat (300) @(posedge core_clk);
        #1;
        clk_en = 1'b0;
        repeat (100) @(posedge core_clk);
        #1;
        clk_en = 1'b1;
      end
      run(50, n, cs, ca);
    join
    `CHK("frozen conv", 1, cs)
    `CHK("frozen len", 1'b1, near(n, CONV + 100))
    $display("test freeze done");
  endtask

  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    fail_count = 0;
    compares = 0;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_powerup;
    t_skip;
    t_pd_after;
    t_modes;
    t_freeze;
    conclude;
  end

  // the tests need some 21000 cycles; allow over twice that
  initial
  begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    conclude;
  end
endmodule
`default_nettype wire
